// file: design/fap_pkg.sv
package fap_pkg;

    // Register addresses on the special-function-register bus
    localparam logic [7:0] CMD_STAT_ADDR   = 8'hd5;
    localparam logic [7:0] DATA_PORT_ADDR  = 8'hd6;

    // Command/status field layout
    localparam int         IDLE_BIT        = 7;
    localparam int         ERR_BIT         = 6;
    localparam int         CMD_MSB         = 3;
    localparam logic [3:0] CMD_RST_VAL     = 4'h0;
    localparam logic       IDLE_RST_VAL    = 1'b1;
    localparam logic       ERR_RST_VAL     = 1'b0;
    localparam logic [7:0] DATA_RST_VAL    = 8'hff;

    // Command codes
    localparam logic [3:0] CMD_READ_MODE   = 4'h0;
    localparam logic [3:0] CMD_VFY_OPT     = 4'h1;
    localparam logic [3:0] CMD_VFY_SEC     = 4'h2;
    localparam logic [3:0] CMD_VFY_UPPER   = 4'h3;
    localparam logic [3:0] CMD_RSVD_A      = 4'h4;
    localparam logic [3:0] CMD_RSVD_B      = 4'h8;
    localparam logic [3:0] CMD_WR_OPT      = 4'h9;
    localparam logic [3:0] CMD_WR_SEC      = 4'ha;
    localparam logic [3:0] CMD_WR_UPPER    = 4'hb;
    localparam logic [3:0] CMD_ER_OPT      = 4'hc;
    localparam logic [3:0] CMD_ER_SEC      = 4'hd;
    localparam logic [3:0] CMD_ER_UPPER    = 4'he;
    localparam logic [3:0] CMD_SYS_RESET   = 4'hf;

    // Security block and option register layout
    localparam logic [7:0] LOCK_ADDR       = 8'h40;
    localparam int         LOCK_LSB        = 3;
    localparam logic [7:0] OPT_DEFINED     = 8'h08;

    // Upper program bank
    localparam logic [15:0] UPPER_BASE     = 16'h2000;
    localparam logic [15:0] UPPER_TOP      = 16'h3fff;

    // Start latency of the busy flag
    localparam int         CLK_PERIOD_PS   = 5000;
    localparam int         START_MAX_NS    = 1000;
    localparam int         START_MAX_CYC   = START_MAX_NS * 1000
                                             / CLK_PERIOD_PS;
    localparam int         START_LAT_CYC   = 1;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_READ = 4'b0100,
        ST_PROG = 4'b1000
    } fap_state_e;

endpackage

// file: design/fap_cmd_decode.sv
`timescale 1ns/1ps
module fap_cmd_decode
    import fap_pkg::*;
(
    // Command code
    input  wire logic [3:0] i_code,
    // Decoded class
    output logic [1:0]      o_nbytes,
    output logic            o_is_op,
    output logic            o_is_read,
    output logic            o_is_upper,
    output logic            o_is_reset
);

    always_comb begin
        o_nbytes   = 2'd0;
        o_is_op    = 1'b1;
        o_is_read  = 1'b0;
        o_is_upper = 1'b0;
        o_is_reset = 1'b0;
        case (i_code)
            CMD_VFY_OPT: begin
                o_is_read  = 1'b1;
            end
            CMD_VFY_SEC: begin
                o_is_read  = 1'b1;
                o_nbytes   = 2'd1;
            end
            CMD_VFY_UPPER: begin
                o_is_read  = 1'b1;
                o_is_upper = 1'b1;
                o_nbytes   = 2'd2;
            end
            CMD_WR_OPT: o_nbytes = 2'd1;
            CMD_WR_SEC: o_nbytes = 2'd2;
            CMD_WR_UPPER: begin
                o_is_upper = 1'b1;
                o_nbytes   = 2'd3;
            end
            CMD_ER_OPT, CMD_ER_SEC, CMD_ER_UPPER: o_nbytes = 2'd0;
            CMD_SYS_RESET: begin
                o_is_op    = 1'b0;
                o_is_reset = 1'b1;
            end
            default: o_is_op = 1'b0;
        endcase
    end

endmodule

// file: design/fap_bank_check.sv
`timescale 1ns/1ps
module fap_bank_check #(
    parameter logic [15:0] BASE = 16'h2000,
    parameter logic [15:0] TOP  = 16'h3fff
) (
    // Address under test
    input  wire logic [15:0] i_addr,
    // Inside the writable bank
    output logic             o_ok
);

    if (BASE > TOP) begin : g_bad_range
        $error("Bank base lies above bank top");
    end

    assign o_ok = (i_addr >= BASE) && (i_addr <= TOP);

endmodule

// file: design/fap_sequencer.sv
`timescale 1ns/1ps
module fap_sequencer
    import fap_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Special-function-register bus
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    input  wire logic [7:0]  i_sfr_wdata,
    input  wire logic        i_ta_open,
    output logic [7:0]       o_sfr_rdata,
    // Flash array
    output logic             o_flash_req,
    output logic [3:0]       o_flash_op,
    output logic [15:0]      o_flash_addr,
    output logic [7:0]       o_flash_wdata,
    input  wire logic [7:0]  i_flash_rdata,
    input  wire logic        i_flash_done,
    input  wire logic        i_flash_fail,
    // System
    output logic             o_sys_reset,
    output logic             o_upper_exec_en
);
    import fap_pkg::*;

    if (START_LAT_CYC > START_MAX_CYC) begin : g_bad_lat
        $error("Start latency exceeds the busy limit");
    end

    fap_state_e  st_r,      st_nxt;
    logic [3:0]  cmd_r,     cmd_nxt;
    logic        idle_r,    idle_nxt;
    logic        err_r,     err_nxt;
    logic [1:0]  cnt_r,     cnt_nxt;
    logic [7:0]  buf_r [3], buf_nxt [3];
    logic [7:0]  data_r,    data_nxt;
    logic        req_r,     req_nxt;
    logic [3:0]  op_r,      op_nxt;
    logic [15:0] faddr_r,   faddr_nxt;
    logic [7:0]  fwdata_r,  fwdata_nxt;
    logic        srst_r,    srst_nxt;
    logic        exec_r,    exec_nxt;
    logic [7:0]  rdata_r,   rdata_nxt;

    logic        cmd_stat_wr;
    logic        data_port_wr;
    logic [1:0]  cur_nbytes;
    logic        cur_is_op;
    logic        cur_is_read;
    logic        cur_is_upper;
    logic [1:0]  new_nbytes;
    logic        new_is_op;
    logic        new_is_reset;
    logic        new_is_read;
    logic        new_is_upper;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic        bank_ok;
    logic        last_byte;
    logic        go;

    fap_cmd_decode u_dec_cur (
        .i_code     (cmd_r),
        .o_nbytes   (cur_nbytes),
        .o_is_op    (cur_is_op),
        .o_is_read  (cur_is_read),
        .o_is_upper (cur_is_upper),
        .o_is_reset ()
    );

    fap_cmd_decode u_dec_new (
        .i_code     (i_sfr_wdata[CMD_MSB:0]),
        .o_nbytes   (new_nbytes),
        .o_is_op    (new_is_op),
        .o_is_read  (new_is_read),
        .o_is_upper (new_is_upper),
        .o_is_reset (new_is_reset)
    );

    // Address assembled from stored and incoming bytes
    fap_bank_check #(
        .BASE (UPPER_BASE),
        .TOP  (UPPER_TOP)
    ) u_bank (
        .i_addr (cmd_is_word_addr() ? {b0, b1} : {8'h00, b0}),
        .o_ok   (bank_ok)
    );

    function automatic logic cmd_is_word_addr();
        cmd_is_word_addr = (cmd_r == CMD_VFY_UPPER) ||
                           (cmd_r == CMD_WR_UPPER);
    endfunction

    // Bus strobes; lock bits play no part here
    assign cmd_stat_wr = i_sfr_wr && (i_sfr_addr == CMD_STAT_ADDR)
                         && i_ta_open;
    assign data_port_wr = i_sfr_wr && (i_sfr_addr == DATA_PORT_ADDR)
                          && (st_r == ST_LOAD);
    assign b0 = (cnt_r == 2'd0) ? i_sfr_wdata : buf_r[0];
    assign b1 = (cnt_r == 2'd1) ? i_sfr_wdata : buf_r[1];
    assign b2 = (cnt_r == 2'd2) ? i_sfr_wdata : buf_r[2];
    assign last_byte = data_port_wr && (cnt_r + 2'd1 == cur_nbytes);
    assign go = last_byte && (!cur_is_upper || bank_ok);

    always_comb begin
        st_nxt     = st_r;
        cmd_nxt    = cmd_r;
        idle_nxt   = idle_r;
        err_nxt    = err_r;
        cnt_nxt    = cnt_r;
        buf_nxt    = buf_r;
        data_nxt   = data_r;
        req_nxt    = 1'b0;
        op_nxt     = op_r;
        faddr_nxt  = faddr_r;
        fwdata_nxt = fwdata_r;
        srst_nxt   = 1'b0;
        case (st_r)
            ST_IDLE, ST_LOAD: begin
                if (cmd_stat_wr) begin
                    cmd_nxt = i_sfr_wdata[CMD_MSB:0];
                    cnt_nxt = 2'd0;
                    st_nxt  = ST_IDLE;
                    srst_nxt = new_is_reset;
                    if (new_is_op) begin
                        err_nxt = 1'b0;
                        op_nxt  = i_sfr_wdata[CMD_MSB:0];
                        if (new_nbytes == 2'd0) begin
                            // Erases and option verify need no bytes
                            req_nxt   = 1'b1;
                            idle_nxt  = new_is_read;
                            faddr_nxt = 16'h0000;
                            st_nxt    = new_is_read ? ST_READ : ST_PROG;
                        end else begin
                            st_nxt = ST_LOAD;
                        end
                    end
                end else if (data_port_wr) begin
                    buf_nxt[cnt_r] = i_sfr_wdata;
                    cnt_nxt        = cnt_r + 2'd1;
                    if (last_byte) begin
                        st_nxt  = ST_IDLE;
                        cnt_nxt = 2'd0;
                        if (!go) begin
                            err_nxt = 1'b1;
                        end else begin
                            req_nxt  = 1'b1;
                            idle_nxt = cur_is_read;
                            st_nxt   = cur_is_read ? ST_READ : ST_PROG;
                            case (cmd_r)
                                CMD_VFY_SEC: begin
                                    faddr_nxt = {8'h00, b0};
                                end
                                CMD_VFY_UPPER: begin
                                    faddr_nxt = {b0, b1};
                                end
                                CMD_WR_OPT: begin
                                    fwdata_nxt = b0;
                                end
                                CMD_WR_SEC: begin
                                    faddr_nxt  = {8'h00, b0};
                                    fwdata_nxt = b1;
                                    if (b0 == LOCK_ADDR) begin
                                        fwdata_nxt[LOCK_LSB]   = b1[LOCK_LSB+2];
                                        fwdata_nxt[LOCK_LSB+2] = b1[LOCK_LSB];
                                    end
                                end
                                CMD_WR_UPPER: begin
                                    faddr_nxt  = {b0, b1};
                                    fwdata_nxt = b2;
                                end
                                default: faddr_nxt = faddr_r;
                            endcase
                        end
                    end
                end
            end
            ST_READ: begin
                // Array answers in the same cycle as the request
                idle_nxt = 1'b1;
                st_nxt   = ST_IDLE;
                if (op_r == CMD_VFY_OPT) begin
                    data_nxt = i_flash_rdata | ~OPT_DEFINED;
                end else begin
                    data_nxt = i_flash_rdata;
                end
            end
            ST_PROG: begin
                if (i_flash_fail) begin
                    err_nxt  = 1'b1;
                    idle_nxt = 1'b1;
                    st_nxt   = ST_IDLE;
                end else if (i_flash_done) begin
                    idle_nxt = 1'b1;
                    st_nxt   = ST_IDLE;
                end
            end
            default: begin
                st_nxt   = ST_IDLE;
                idle_nxt = 1'b1;
            end
        endcase
    end

    // Execution of the upper bank only in read mode or a no-op code
    always_comb begin
        exec_nxt = (cmd_nxt == CMD_READ_MODE) ||
                   (!new_is_op && !new_is_reset && cmd_stat_wr
                    && st_r != ST_READ && st_r != ST_PROG) ||
                   (exec_r && !cmd_stat_wr);
        if (st_r == ST_READ || st_r == ST_PROG) begin
            exec_nxt = exec_r;
        end
    end

    // Registered read data; flags are read-only
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_sfr_rd && i_sfr_addr == CMD_STAT_ADDR) begin
            rdata_nxt[IDLE_BIT]  = idle_r;
            rdata_nxt[ERR_BIT]   = err_r;
            rdata_nxt[CMD_MSB:0] = cmd_r;
        end else if (i_sfr_rd && i_sfr_addr == DATA_PORT_ADDR
                     && cmd_r != CMD_READ_MODE) begin
            rdata_nxt = data_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r     <= ST_IDLE;
            cmd_r    <= CMD_RST_VAL;
            idle_r   <= IDLE_RST_VAL;
            err_r    <= ERR_RST_VAL;
            cnt_r    <= 2'd0;
            buf_r    <= '{default: 8'h00};
            data_r   <= DATA_RST_VAL;
            req_r    <= 1'b0;
            op_r     <= CMD_RST_VAL;
            faddr_r  <= 16'h0000;
            fwdata_r <= 8'h00;
            srst_r   <= 1'b0;
            exec_r   <= 1'b1;
            rdata_r  <= 8'h00;
        end else begin
            st_r     <= st_nxt;
            cmd_r    <= cmd_nxt;
            idle_r   <= idle_nxt;
            err_r    <= err_nxt;
            cnt_r    <= cnt_nxt;
            buf_r    <= buf_nxt;
            data_r   <= data_nxt;
            req_r    <= req_nxt;
            op_r     <= op_nxt;
            faddr_r  <= faddr_nxt;
            fwdata_r <= fwdata_nxt;
            srst_r   <= srst_nxt;
            exec_r   <= exec_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign o_sfr_rdata     = rdata_r;
    assign o_flash_req     = req_r;
    assign o_flash_op      = op_r;
    assign o_flash_addr    = faddr_r;
    assign o_flash_wdata   = fwdata_r;
    assign o_sys_reset     = srst_r;
    assign o_upper_exec_en = exec_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    property p_start;
        go && !cur_is_read |=> o_flash_req && !idle_r;
    endproperty
    a_start: assert property (p_start)
        else $error("Last byte did not start the operation");

    property p_busy_fall;
        go && !cur_is_read |-> ##[1:2] !idle_r;
    endproperty
    a_busy_fall: assert property (p_busy_fall)
        else $error("Idle flag did not fall in time");

    property p_hold_low;
        st_r == ST_PROG && !i_flash_done && !i_flash_fail |=> !idle_r;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("Idle flag rose before the operation ended");

    property p_fail;
        st_r == ST_PROG && i_flash_fail |=> err_r && idle_r
            && st_r == ST_IDLE;
    endproperty
    a_fail: assert property (p_fail)
        else $error("Failure did not set the error flag");

    property p_ignore_busy;
        i_sfr_wr && i_sfr_addr == CMD_STAT_ADDR && !idle_r
            |=> $stable(cmd_r);
    endproperty
    a_ignore_busy: assert property (p_ignore_busy)
        else $error("Command changed during an operation");

    property p_timed;
        i_sfr_wr && i_sfr_addr == CMD_STAT_ADDR && !i_ta_open
            && st_r != ST_READ |=> $stable(cmd_r);
    endproperty
    a_timed: assert property (p_timed)
        else $error("Command taken without timed access");

    property p_sys_reset;
        cmd_stat_wr && i_sfr_wdata[CMD_MSB:0] == CMD_SYS_RESET
            && (st_r == ST_IDLE || st_r == ST_LOAD) |=> o_sys_reset;
    endproperty
    a_sys_reset: assert property (p_sys_reset)
        else $error("Reset command gave no system reset");

    property p_bank;
        last_byte && cur_is_upper && !bank_ok
            |=> !o_flash_req && err_r;
    endproperty
    a_bank: assert property (p_bank)
        else $error("Out-of-bank access was issued");

    property p_one_shot;
        st_r == ST_IDLE && i_sfr_wr && i_sfr_addr == DATA_PORT_ADDR
            && !cmd_stat_wr |=> !o_flash_req && cnt_r == 2'd0;
    endproperty
    a_one_shot: assert property (p_one_shot)
        else $error("Data port accepted bytes without a command");

    property p_exec;
        cmd_r == CMD_WR_UPPER |-> !o_upper_exec_en;
    endproperty
    a_exec: assert property (p_exec)
        else $error("Upper bank executable outside read mode");

endmodule

// file: dv/fap_flash_model.sv
`timescale 1ns/1ps
module fap_flash_model (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Request from the sequencer
    input  wire logic        i_req,
    input  wire logic [3:0]  i_op,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    // Answer to the sequencer
    output logic [7:0]       o_rdata,
    output logic             o_done,
    output logic             o_fail,
    // Test controls
    input  wire logic        i_slow,
    input  wire logic        i_bad
);
    logic [7:0] up [int];
    logic [7:0] sec [int];
    logic [7:0] opt = 8'hff;
    logic [7:0] rv, pat;
    logic       hold;
    int         cnt;
    // Unwritten cells read as erased
    always @* begin
        if (i_op == 4'h1)
            rv = opt;
        else if (i_op == 4'h2)
            rv = sec.exists(i_addr) ? sec[i_addr] : 8'hff;
        else
            rv = up.exists(i_addr) ? up[i_addr] : 8'hff;
    end
    // Answer only around the request, a moving pattern otherwise
    assign o_rdata = (i_req || hold) ? rv : pat;
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hold   <= 1'b0;
            pat    <= 8'h5a;
            cnt    <= 0;
            o_done <= 1'b0;
            o_fail <= 1'b0;
        end else begin
            hold   <= i_req;
            pat    <= pat + 8'h3b;
            o_done <= 1'b0;
            o_fail <= 1'b0;
            cnt    <= (cnt > 0) ? cnt - 1 : 0;
            if (i_req && i_op[3])
                cnt <= i_slow ? 40 : 3;
            if (cnt == 1 && i_bad)
                o_fail <= 1'b1;
            if (cnt == 1 && !i_bad) begin
                o_done <= 1'b1;
                case (i_op)
                    4'h9: opt <= i_wdata;
                    4'ha: sec[i_addr] = i_wdata;
                    4'hb: up[i_addr] = i_wdata;
                    4'hc: opt <= 8'hff;
                    4'hd: sec.delete();
                    4'he: up.delete();
                    default: ;
                endcase
            end
        end
    end
endmodule

// file: dv/fap_sequencer_tb.sv
`timescale 1ns/1ps
module fap_sequencer_tb;
    import fap_pkg::*;
    typedef struct {
        logic        rd;
        logic [27:0] val;
        logic [27:0] msk;
        string       name;
    } fap_note_s;
    localparam logic [27:0] M_OP = 28'hf000000;
    localparam logic [27:0] M_OA = 28'hfffff00;
    logic        clk = 1'b0, rstn = 1'b1, wr = 1'b0, rd = 1'b0;
    logic        ta = 1'b0, slow = 1'b0, bad = 1'b0, quiet = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, f_rd, f_wd, d;
    logic        rd_seen, req, done, fail, sys_rst, exec_en, pulse;
    logic [3:0]  op;
    logic [15:0] faddr, a;
    int          err_count = 0, tests_run = 0, cyc = 0, seed = 22;
    fap_note_s   notes[$];
    fap_note_s   n;

    fap_sequencer i_dut (
        .i_clk(clk), .i_rstn(rstn), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wdata), .i_ta_open(ta),
        .o_sfr_rdata(rdata), .o_flash_req(req), .o_flash_op(op),
        .o_flash_addr(faddr), .o_flash_wdata(f_wd), .i_flash_rdata(f_rd),
        .i_flash_done(done), .i_flash_fail(fail), .o_sys_reset(sys_rst),
        .o_upper_exec_en(exec_en)
    );
    fap_flash_model i_flash (
        .i_clk(clk), .i_rstn(rstn), .i_req(req), .i_op(op),
        .i_addr(faddr), .i_wdata(f_wd), .o_rdata(f_rd), .o_done(done),
        .o_fail(fail), .i_slow(slow), .i_bad(bad)
    );

    always #2.5 clk = ~clk;

    task automatic check(string nm, logic [28:0] e, logic [28:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict;
        if (err_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Cycle ceiling and read pipeline
    always @(posedge clk) begin
        rd_seen <= rd && !quiet;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            check("timeout", 29'h0, 29'h1);
            print_verdict;
        end
    end

    // Result watcher takes the oldest note
    always @(negedge clk) begin
        if (rd_seen || req) begin
            if (notes.size() == 0)
                check("spare result", 29'h0, 29'h1);
            else begin
                n = notes.pop_front();
                check(n.name, {n.rd, n.val & n.msk}, {rd_seen,
                      (rd_seen ? {20'h0, rdata} : {op, faddr, f_wd})
                      & n.msk});
            end
        end
    end

    task automatic wr_reg(logic [7:0] ad, logic [7:0] dt, logic t = 1);
        addr  = ad;
        wdata = dt;
        ta    = t;
        wr    = 1'b1;
        @(negedge clk);
        wr    = 1'b0;
        ta    = 1'b0;
        pulse = sys_rst;
        @(negedge clk);
    endtask

    task automatic rd_exp(string nm, logic [7:0] ad, logic [7:0] e);
        notes.push_back('{1'b1, {20'h0, e}, 28'hff, nm});
        addr = ad;
        rd   = 1'b1;
        @(negedge clk);
        rd   = 1'b0;
        @(negedge clk);
    endtask

    task automatic wait_idle(logic lvl, int lim);
        logic [7:0] v;
        for (int k = 0; k < lim; k++) begin
            quiet = 1'b1;
            addr  = CMD_STAT_ADDR;
            rd    = 1'b1;
            @(negedge clk);
            rd    = 1'b0;
            quiet = 1'b0;
            v     = rdata;
            @(negedge clk);
            if (v[IDLE_BIT] === lvl)
                break;
        end
        check("idle flag", 29'(lvl), 29'(v[IDLE_BIT]));
    endtask

    // Command, its bytes high first, then wait for the operation
    task automatic run(logic [3:0] c, int nb, logic [23:0] b,
                       logic [27:0] v, logic [27:0] m);
        notes.push_back('{1'b0, v, m, "flash request"});
        wr_reg(CMD_STAT_ADDR, {4'h0, c});
        for (int i = nb - 1; i >= 0; i--)
            wr_reg(DATA_PORT_ADDR, b[8*i +: 8]);
        if (c[3]) begin
            wait_idle(1'b0, START_MAX_CYC / 2);
            wr_reg(CMD_STAT_ADDR, {4'h0, CMD_ER_UPPER});
            check("exec", 29'h0, 29'(exec_en));
            wait_idle(1'b1, 100);
        end else
            repeat (2) @(negedge clk);
    endtask

    task automatic vu(logic [15:0] ad, logic [7:0] e);
        run(CMD_VFY_UPPER, 2, {8'h0, ad}, {CMD_VFY_UPPER, ad, 8'h0}, M_OA);
        rd_exp("upper byte", DATA_PORT_ADDR, e);
    endtask

    task automatic vs(logic [7:0] e);
        run(CMD_VFY_SEC, 1, {16'h0, LOCK_ADDR},
            {CMD_VFY_SEC, 8'h0, LOCK_ADDR, 8'h0}, M_OA);
        rd_exp("security byte", DATA_PORT_ADDR, e);
    endtask

    task automatic vo(logic [7:0] e);
        run(CMD_VFY_OPT, 0, 24'h0, {CMD_VFY_OPT, 24'h0}, M_OP);
        rd_exp("option byte", DATA_PORT_ADDR, e);
    endtask

    task automatic pv(logic [15:0] ad, logic [7:0] dt);
        run(CMD_WR_UPPER, 3, {ad, dt}, {CMD_WR_UPPER, ad, dt}, '1);
        rd_exp("status", CMD_STAT_ADDR, {4'h8, CMD_WR_UPPER});
        wr_reg(DATA_PORT_ADDR, dt);
        vu(ad, dt);
    endtask

    initial begin
        rstn = 1'b0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        rd_exp("status", CMD_STAT_ADDR, 8'h80);
        rd_exp("data port", DATA_PORT_ADDR, 8'h00);
        rd_exp("unmapped", 8'h00, 8'h00);
        check("exec", 29'h1, 29'(exec_en));
        wr_reg(CMD_STAT_ADDR, {4'h0, CMD_WR_UPPER}, 0);
        wr_reg(DATA_PORT_ADDR, 8'h20);
        rd_exp("status", CMD_STAT_ADDR, 8'h80);
        pv(UPPER_BASE, 8'h3c);
        slow = 1'b1;
        pv(UPPER_TOP, 8'hc3);
        for (int i = 0; i < 2; i++) begin
            a = i ? UPPER_TOP + 16'h1 : UPPER_BASE - 16'h1;
            wr_reg(CMD_STAT_ADDR, {4'h0, CMD_WR_UPPER});
            wr_reg(DATA_PORT_ADDR, a[15:8]);
            wr_reg(DATA_PORT_ADDR, a[7:0]);
            wr_reg(DATA_PORT_ADDR, 8'h00);
            rd_exp("status", CMD_STAT_ADDR, 8'hcb);
        end
        bad = 1'b1;
        run(CMD_ER_UPPER, 0, 24'h0, {CMD_ER_UPPER, 24'h0}, M_OP);
        rd_exp("status", CMD_STAT_ADDR, 8'hce);
        bad = 1'b0;
        run(CMD_WR_OPT, 1, 24'h0, {CMD_WR_OPT, 24'h0}, 28'hf0000ff);
        vo(8'hf7);
        run(CMD_ER_OPT, 0, 24'h0, {CMD_ER_OPT, 24'h0}, M_OP);
        vo(8'hff);
        run(CMD_WR_SEC, 2, {8'h0, LOCK_ADDR, 8'h27},
            {CMD_WR_SEC, 8'h0, LOCK_ADDR, 8'h0f}, '1);
        vs(8'h0f);
        for (int i = 0; i < 3; i++) begin
            a    = UPPER_BASE | 16'($random(seed) & 32'h1fff);
            d    = 8'($random(seed));
            slow = d[0];
            pv(a, d);
        end
        run(CMD_ER_SEC, 0, 24'h0, {CMD_ER_SEC, 24'h0}, M_OP);
        vs(8'hff);
        run(CMD_ER_UPPER, 0, 24'h0, {CMD_ER_UPPER, 24'h0}, M_OP);
        vu(a, 8'hff);
        wr_reg(CMD_STAT_ADDR, 8'h40);
        rd_exp("status", CMD_STAT_ADDR, 8'h80);
        check("exec", 29'h1, 29'(exec_en));
        for (int i = 4; i < 9; i++) begin
            wr_reg(CMD_STAT_ADDR, 8'(i));
            wr_reg(DATA_PORT_ADDR, 8'h20);
            rd_exp("status", CMD_STAT_ADDR, 8'h80 | 8'(i));
            check("exec", 29'h1, 29'(exec_en));
        end
        wr_reg(CMD_STAT_ADDR, {4'h0, CMD_SYS_RESET});
        check("sys reset", 29'h1, 29'(pulse));
        check("sys reset", 29'h0, 29'(sys_rst));
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        rd_exp("status", CMD_STAT_ADDR, 8'h80);
        check("notes left", 29'h0, 29'(notes.size()));
        print_verdict;
    end
endmodule
